// File: design/usg_unattended_start_guard.v
// start interlock of a motor drive: power-up run check and latched trip
// Summary of operation
// - guard off and run present at power-up: motor starts at once.
// - guard on: no automatic start at power-up.
// - run active right after power-up with guard on raises the trip.
// - trip reported as fault code 13 and held as active fault.
// - trip clears when run request drops; fresh run then accepted.
// - trip also clears on reset terminal or keypad stop/reset.
// - reset-cleared trip with run still held restarts motor at once.
// - after undervoltage trip cleared by reset, guard check still applies.
// - guard input is function code 13 on any of eight terminals.
// - after external trip cancel with guard on, no self restart.
`include "usg_consts.vh"
`default_nettype none

module usg_unattended_start_guard #(
   parameter N_TERM      = 8,
   parameter INIT_CYCLES = `USG_INIT_CYCLES
) (
   input  wire              clk_sys,          // controller clock, 40 MHz
   input  wire              reset_n,          // power-on reset, active low
   input  wire [N_TERM-1:0] term_in,          // multifunction input pins
   input  wire [5*N_TERM-1:0] input_terminal_function_select, // 5b each
   input  wire              run_request,      // run command pin
   input  wire              keypad_reset,     // keypad stop/reset key
   input  wire              undervoltage,     // supply undervoltage flag
   output reg               motor_drive,      // drive the motor
   output reg               alarm_out,        // alarm output
   output reg  [7:0]        fault_code        // active fault code
);

   ////////////////////////////////////////////////////////////////////
   // reset release and input synchronisers
   reg              rst_meta;
   reg              rst_sync;
   reg [N_TERM+2:0] in_meta;
   reg [N_TERM+2:0] in_sync;

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // pins come from outside the clock domain, so two flops each
   always @(posedge clk_sys or negedge rst_sync) begin
      if (!rst_sync) begin
         in_meta <= {(N_TERM+3){1'b0}};
         in_sync <= {(N_TERM+3){1'b0}};
      end else begin
         in_meta <= {undervoltage, keypad_reset, run_request, term_in};
         in_sync <= in_meta;
      end
   end

   wire [N_TERM-1:0] term_s = in_sync[N_TERM-1:0];
   wire run_s = in_sync[N_TERM];
   wire key_s = in_sync[N_TERM+1];
   wire uv_s  = in_sync[N_TERM+2];

   ////////////////////////////////////////////////////////////////////
   // terminal function decode, shared by all three functions
   function func_active;
      input [N_TERM-1:0]   pins;
      input [5*N_TERM-1:0] sel;
      input [4:0]          code;
      integer i;
      begin
         func_active = 1'b0;
         for (i = 0; i < N_TERM; i = i + 1)
            if (sel[5*i +: 5] == code && pins[i])
               func_active = 1'b1;
      end
   endfunction

   wire guard_on = func_active(term_s, input_terminal_function_select,
                               `USG_FUNC_START_GUARD);
   wire ext_s    = func_active(term_s, input_terminal_function_select,
                               `USG_FUNC_EXT_FAULT);
   wire rst_term = func_active(term_s, input_terminal_function_select,
                               `USG_FUNC_RESET_TERM);
   wire any_reset = rst_term | key_s;

   ////////////////////////////////////////////////////////////////////
   // edge history
   reg run_d;
   reg ext_d;
   reg rst_d;
   always @(posedge clk_sys or negedge rst_sync) begin
      if (!rst_sync) begin
         run_d <= 1'b0;
         ext_d <= 1'b0;
         rst_d <= 1'b0;
      end else begin
         run_d <= run_s;
         ext_d <= ext_s;
         rst_d <= any_reset;
      end
   end
   wire run_rise  = run_s & ~run_d;
   wire ext_rise  = ext_s & ~ext_d;
   wire rst_fall  = ~any_reset & rst_d;

   ////////////////////////////////////////////////////////////////////
   // power-up settle counter; a long count, so it is a parameter
   reg [31:0] init_cnt;
   wire       init_done = (init_cnt == INIT_CYCLES);
   always @(posedge clk_sys or negedge rst_sync) begin
      if (!rst_sync)
         init_cnt <= 32'h0000_0000;
      else if (!init_done)
         init_cnt <= init_cnt + 32'h0000_0001;
   end

   ////////////////////////////////////////////////////////////////////
   // state machine, one-hot
   localparam [4:0] ST_INIT  = 5'h01;
   localparam [4:0] ST_STOP  = 5'h02;
   localparam [4:0] ST_RUN   = 5'h04;
   localparam [4:0] ST_GUARD = 5'h08;
   localparam [4:0] ST_TRIP  = 5'h10;

   reg [4:0] state;
   reg [4:0] next_state;
   reg [7:0] trip_code;
   reg [7:0] next_trip_code;
   reg       uv_reset;      // undervoltage reset pending: re-check run
   reg       next_uv_reset;

   always @* begin
      next_state     = state;
      next_trip_code = trip_code;
      next_uv_reset  = uv_reset;
      case (state)
         ST_INIT: begin
            if (init_done) begin
               // one sample of run after init is the power-up run state
               if (run_s && guard_on) begin
                  next_state     = ST_GUARD;
               end else if (run_s) begin
                  next_state = ST_RUN;
               end else begin
                  next_state = ST_STOP;
               end
            end
         end
         ST_STOP: begin
            if (run_rise) begin
               next_state = ST_RUN;
            end else if (any_reset && run_s) begin
               // run held through a cancelled trip: a fresh reset restarts
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!run_s)
               next_state = ST_STOP;
         end
         ST_GUARD: begin
            // trip latched; run drop clears quietly, reset restarts
            if (!run_s) begin
               next_state = ST_STOP;
            end else if (any_reset) begin
               next_state = ST_RUN;
            end
         end
         ST_TRIP: begin
            // general trip: cleared only when the reset is let go
            if (rst_fall) begin
               if (uv_reset && guard_on && run_s) begin
                  next_state = ST_GUARD;
               end else if (guard_on) begin
                  next_state = ST_STOP;
               end else if (run_s) begin
                  next_state = ST_RUN;
               end else begin
                  next_state = ST_STOP;
               end
               next_uv_reset = 1'b0;
            end
         end
         default: begin
            next_state = ST_INIT;
         end
      endcase
      // fault sources override the normal states
      if (state != ST_INIT && state != ST_TRIP) begin
         if (uv_s) begin
            next_state     = ST_TRIP;
            next_trip_code = `USG_CODE_UV;
            next_uv_reset  = 1'b1;
         end else if (ext_rise) begin
            next_state     = ST_TRIP;
            next_trip_code = `USG_CODE_EXT;
         end
      end
   end

   always @(posedge clk_sys or negedge rst_sync) begin
      if (!rst_sync) begin
         state     <= ST_INIT;
         trip_code <= `USG_CODE_NONE;
         uv_reset  <= 1'b0;
      end else begin
         state     <= next_state;
         trip_code <= next_trip_code;
         uv_reset  <= next_uv_reset;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // registered outputs follow the next state
   always @(posedge clk_sys or negedge rst_sync) begin
      if (!rst_sync) begin
         motor_drive <= 1'b0;
         alarm_out   <= 1'b0;
         fault_code  <= `USG_CODE_NONE;
      end else begin
         motor_drive <= (next_state == ST_RUN);
         alarm_out   <= (next_state == ST_GUARD) ||
                        (next_state == ST_TRIP);
         if (next_state == ST_GUARD)
            fault_code <= `USG_CODE_START_GUARD;
         else if (next_state == ST_TRIP)
            fault_code <= next_trip_code;
         else
            fault_code <= `USG_CODE_NONE;
      end
   end

endmodule // usg_unattended_start_guard

`default_nettype wire

// File: design/usg_consts.vh
// constants for the unattended start guard
`ifndef USG_CONSTS_VH
`define USG_CONSTS_VH
// function code that selects the start guard on a multifunction terminal
`define USG_FUNC_START_GUARD   5'h0D
// function code that selects the external fault input
`define USG_FUNC_EXT_FAULT     5'h0C
// function code that selects the reset terminal
`define USG_FUNC_RESET_TERM    5'h12
// fault codes shown on the fault code output
`define USG_CODE_NONE          8'h00
`define USG_CODE_UV            8'h09
`define USG_CODE_EXT           8'h0C
`define USG_CODE_START_GUARD   8'h0D
// power-up settle time before the run request is sampled, in microseconds
`define USG_INIT_TIME_US       10
// controller clock rate in MHz
`define USG_CLK_MHZ            40
// settle time in cycles, a least time so the product is exact
`define USG_INIT_CYCLES        (`USG_INIT_TIME_US * `USG_CLK_MHZ)
`endif

// File: test/usg_guard_monitor.sv
// port checker for the unattended start guard
`default_nettype none
module usg_guard_monitor #(parameter N_TERM = 8) (
   input wire logic                clk_sys,      // clock
   input wire logic                reset_n,      // reset, active low
   input wire logic [N_TERM-1:0]   term_in,      // terminals
   input wire logic [5*N_TERM-1:0] input_terminal_function_select, // codes
   input wire logic                run_request,  // run
   input wire logic                keypad_reset, // keypad key
   input wire logic                undervoltage, // supply low
   input wire logic                motor_drive,  // drive
   input wire logic                alarm_out,    // alarm
   input wire logic [7:0]          fault_code    // fault
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////////////////////////////////
   // windows allow for the two sync flops ahead of the output flop
   alarm_code_a: assert property (fault_code != 8'h00 |-> alarm_out)
      else $error("fault code without alarm");
   code_known_a: assert property (alarm_out |-> fault_code inside
      {8'h09, 8'h0C, 8'h0D}) else $error("alarm with odd code");
   trip_stop_a: assert property (fault_code == 8'h0D |-> !motor_drive)
      else $error("motor driven in guard trip");
   trip_held_a: assert property ((fault_code == 8'h0D && run_request &&
      !keypad_reset && !undervoltage && term_in[N_TERM-1:1] == '0)[*3]
      |=> fault_code == 8'h0D) else $error("guard trip dropped");
   drop_clear_a: assert property ($fell(run_request) &&
      fault_code == 8'h0D && !undervoltage |-> ##[1:4] fault_code == 8'h00)
      else $error("run drop left trip");
   key_restart_a: assert property ($rose(keypad_reset) &&
      fault_code == 8'h0D && run_request |-> ##[1:4] motor_drive && !alarm_out)
      else $error("keypad reset gave no restart");
   start_run_a: assert property ($rose(motor_drive) |->
      $past(run_request, 2)) else $error("motor started without run");
   init_quiet_a: assert property ($rose(reset_n) |->
      (!motor_drive && fault_code == 8'h00)[*3]) else $error("early output");
   // main scenarios
   cover property (fault_code == 8'h0D);
   cover property (fault_code == 8'h09);
   cover property (fault_code == 8'h0C);
   cover property ($rose(keypad_reset) && alarm_out);
endmodule // usg_guard_monitor
`default_nettype wire

// File: test/usg_term_model.sv
// model of the control terminals and keypad facing the guard
`include "usg_consts.vh"
`default_nettype none
module usg_term_model (
   input  wire logic [5:0] want,         // ext,guard,run,key,uv,reset term
   output logic [7:0]      term_in,      // terminals
   output logic [39:0]     sel,          // function codes
   output logic            run_request,  // run
   output logic            keypad_reset, // keypad key
   output logic            undervoltage  // supply low
);
   timeunit 1ns;
   timeprecision 1ps;
   // guard on terminal 0, reset on 1, external fault on 2; rest stay low
   assign sel = {25'h0, `USG_FUNC_EXT_FAULT, `USG_FUNC_RESET_TERM,
                 `USG_FUNC_START_GUARD};
   assign term_in = {5'h00, want[5], want[0], want[4]};
   assign run_request = want[3];
   assign keypad_reset = want[2];
   assign undervoltage = want[1];
endmodule // usg_term_model
`default_nettype wire

// File: test/usg_unattended_start_guard_tb_top.sv
// bench for the unattended start guard
`default_nettype none
module usg_unattended_start_guard_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk_sys, reset_n, run_request, keypad_reset, undervoltage;
   logic       motor_drive, alarm_out;
   logic [5:0] want;
   logic [7:0] term_in, fault_code;
   logic [39:0] sel;
   int         mismatches = 0;
   int         total_checks = 0;
   int         cycles = 0;
   usg_term_model TERM (.want(want), .term_in(term_in), .sel(sel),
      .run_request(run_request), .keypad_reset(keypad_reset),
      .undervoltage(undervoltage));
   usg_unattended_start_guard #(.N_TERM(8), .INIT_CYCLES(4)) DUT (
      .clk_sys(clk_sys), .reset_n(reset_n), .term_in(term_in),
      .input_terminal_function_select(sel), .run_request(run_request),
      .keypad_reset(keypad_reset), .undervoltage(undervoltage),
      .motor_drive(motor_drive), .alarm_out(alarm_out),
      .fault_code(fault_code));
   ////////////////////////////////////////////////////////////////////
   // shared helpers; inputs move 1 ns after an edge, except the first settings at time 0
   task automatic summarize;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // expected value is {motor, alarm, code}
   task automatic chk(input logic [9:0] exp);
      total_checks++;
      if ({motor_drive, alarm_out, fault_code} !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t exp=%h got=%h", $time, exp,
            {motor_drive, alarm_out, fault_code});
      end
   endtask
   // 12 cycles cover reset sync, the short settle count and the latency
   task automatic power_up(input logic [4:0] w);
      reset_n = 1'b0;
      want = {1'b0, w};
      step(3);
      reset_n = 1'b1;
      step(12);
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic t_resume;
      power_up(5'b01000);
      chk(10'h200);
      $display("test resume done");
   endtask
   task automatic t_run_drop;
      power_up(5'b11000);
      chk(10'h10D);
      want[3] = 1'b0;
      step(6);
      chk(10'h000);
      want[3] = 1'b1;
      step(6);
      chk(10'h200);
      $display("test run drop done");
   endtask
   // bit 2 is the keypad key, bit 0 the reset terminal
   task automatic t_reset_clear(input int b);
      power_up(5'b11000);
      want[b] = 1'b1;
      step(6);
      chk(10'h200);
      want[b] = 1'b0;
      step(2);
      $display("test reset clear %0d done", b);
   endtask
   task automatic t_uv_recheck;
      power_up(5'b10000);
      chk(10'h000);
      want[3] = 1'b1;
      step(6);
      chk(10'h200);
      want[1] = 1'b1;
      step(6);
      chk(10'h109);
      want[1] = 1'b0;
      want[0] = 1'b1;
      step(6);
      want[0] = 1'b0;
      step(6);
      chk(10'h10D);
      $display("test undervoltage recheck done");
   endtask
   // external fault with guard on: cancel leaves motor off, keypad restarts
   task automatic t_ext_cancel;
      power_up(5'b10000);
      want[3] = 1'b1;
      step(6);
      chk(10'h200);
      want[5] = 1'b1;
      step(6);
      chk(10'h10C);
      want[5] = 1'b0;
      want[0] = 1'b1;
      step(6);
      want[0] = 1'b0;
      step(6);
      chk(10'h000);
      want[2] = 1'b1;
      step(6);
      chk(10'h200);
      want[2] = 1'b0;
      step(2);
      $display("test external cancel done");
   endtask
   ////////////////////////////////////////////////////////////////////
   // clock, main sequence and hang guard
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end
   initial begin
      reset_n = 1'b0;
      want = 6'b000000;
      t_resume();
      t_run_drop();
      t_reset_clear(2);
      t_reset_clear(0);
      t_uv_recheck();
      t_ext_cancel();
      summarize();
   end
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 1000) begin
         mismatches++;
         summarize();
      end
   end
endmodule // usg_unattended_start_guard_tb_top
bind usg_unattended_start_guard usg_guard_monitor #(.N_TERM(N_TERM)) MON (
   .clk_sys(clk_sys), .reset_n(reset_n), .term_in(term_in),
   .input_terminal_function_select(input_terminal_function_select),
   .run_request(run_request), .keypad_reset(keypad_reset),
   .undervoltage(undervoltage), .motor_drive(motor_drive),
   .alarm_out(alarm_out), .fault_code(fault_code));
`default_nettype wire
